// ---- core/cpu_sleep_rotate_set_all_ones_instr_exec.sv ----
// four-phase executor for set-all-ones, rotate-right and sleep, with bus
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`include "exec_defines.svh"
`default_nettype none

module cpu_sleep_rotate_set_all_ones_instr_exec
  import exec_pkg::*;
#(
  parameter int WDT_COUNT_W = 8,
  parameter int WDT_POST_W  = 3
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // instruction stream
  input  wire logic [15:0] instr_i,
  input  wire logic        instr_valid_i,
  output logic             instr_ready_o,
  // wake-up and power state
  input  wire logic        wake_i,
  output logic             sleep_o,
  output logic             osc_run_o,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // interrupt
  output logic             irq_o
);

  phase_e      phase;
  op_e         op;
  logic [7:0]  file_addr_op;
  logic        dest_file;
  logic [7:0]  operand;
  logic [7:0]  rotated;
  logic [7:0]  file_mem [256];
  logic [7:0]  accum;
  logic        timeout_flag, power_down_flag;
  logic [7:0]  win_addr;
  logic        wdt_en;
  logic [`IRQ_BITS-1:0] irq_stat;
  logic [`IRQ_BITS-1:0] irq_mask;
  logic [`IRQ_BITS-1:0] irq_event;
  logic        wdt_expire, wdt_clear, bus_wr, wake_any;
  logic        core_file_wr, core_acc_wr;
  logic [7:0]  core_file_data;
  op_e         next_op;

  // one wait cycle: the access commits on the edge that sees waitrequest low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if ((avs_read_i | avs_write_i) & avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  assign bus_wr = avs_write_i & ~avs_waitrequest_o;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0;
    end else if (avs_read_i & avs_waitrequest_o) begin
      case (avs_address_i)
        `OFS_STATUS: begin
          avs_readdata_o <= {29'h0, sleep_o, power_down_flag, timeout_flag};
        end
        `OFS_ACCUM:     avs_readdata_o <= {24'h0, accum};
        `OFS_FILE_ADDR: avs_readdata_o <= {24'h0, win_addr};
        `OFS_FILE_DATA: avs_readdata_o <= {24'h0, file_mem[win_addr]};
        `OFS_IRQ_STAT:  avs_readdata_o <= {29'h0, irq_stat};
        `OFS_IRQ_MASK:  avs_readdata_o <= {29'h0, irq_mask};
        `OFS_WDT_CTRL:  avs_readdata_o <= {31'h0, wdt_en};
        default:        avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      win_addr <= `RST_BYTE;
      wdt_en   <= `RST_WDT_EN;
      irq_mask <= '0;
    end else if (bus_wr) begin
      case (avs_address_i)
        `OFS_FILE_ADDR: win_addr <= avs_writedata_i[7:0];
        `OFS_WDT_CTRL:  wdt_en   <= avs_writedata_i[`WDT_CTRL_EN];
        `OFS_IRQ_MASK:  irq_mask <= avs_writedata_i[`IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    if (instr_i[15:9] == `OPC_SETALL_HI) begin
      next_op = OP_SETALL;
    end else if (instr_i[15:10] == `OPC_ROT_HI) begin
      next_op = OP_ROTATE;
    end else if (instr_i == `OPC_SLEEP) begin
      next_op = OP_SLEEP;
    end else begin
      next_op = OP_OTHER;
    end
  end

  assign wake_any = wake_i | wdt_expire |
                    (bus_wr & (avs_address_i == `OFS_WAKE) &
                     avs_writedata_i[`WAKE_REQ]);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= PH_DECODE;
    end else begin
      case (phase)
        PH_DECODE: begin
          if (instr_valid_i & instr_ready_o) begin
            phase <= PH_READ;
          end
        end
        PH_READ:    phase <= PH_PROCESS;
        PH_PROCESS: phase <= PH_WRITE;
        PH_WRITE: begin
          // sleep is entered in place of a write
          phase <= (op == OP_SLEEP) ? PH_SLEEP : PH_DECODE;
        end
        PH_SLEEP: begin
          if (wake_any) begin
            phase <= PH_DECODE;
          end
        end
        default: phase <= PH_DECODE;
      endcase
    end
  end

  // accepted only while decoding and awake; a word held across sleep waits
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      instr_ready_o <= 1'b0;
    end else begin
      instr_ready_o <= ((phase == PH_DECODE) & ~(instr_valid_i &
                        instr_ready_o)) |
                       ((phase == PH_WRITE) & (op != OP_SLEEP)) |
                       ((phase == PH_SLEEP) & wake_any);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      op           <= OP_OTHER;
      file_addr_op <= `RST_BYTE;
      dest_file    <= 1'b0;
    end else if ((phase == PH_DECODE) & instr_valid_i & instr_ready_o) begin
      op           <= next_op;
      file_addr_op <= instr_i[7:0];
      dest_file    <= instr_i[9];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      operand <= `RST_BYTE;
    end else if (phase == PH_READ) begin
      operand <= file_mem[file_addr_op];
    end
  end

  rotate_unit #(.WIDTH(8)) u_rotate (
    .operand_i (operand),
    .result_o  (rotated)
  );

  always_comb begin
    core_file_wr   = 1'b0;
    core_acc_wr    = 1'b0;
    core_file_data = rotated;
    if (phase == PH_WRITE) begin
      if (op == OP_SETALL) begin
        core_file_wr   = 1'b1;
        core_file_data = `ALL_ONES;
      end else if (op == OP_ROTATE) begin
        core_file_wr = dest_file;
        core_acc_wr  = ~dest_file;
      end
    end
  end

  // the core wins a same-cycle collision with a bus write to one location
  always_ff @(posedge core_clk_i) begin
    if (core_file_wr) begin
      file_mem[file_addr_op] <= core_file_data;
    end else if (bus_wr & (avs_address_i == `OFS_FILE_DATA)) begin
      file_mem[win_addr] <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accum <= `RST_BYTE;
    end else if (core_acc_wr) begin
      accum <= rotated;
    end else if (bus_wr & (avs_address_i == `OFS_ACCUM)) begin
      accum <= avs_writedata_i[7:0];
    end
  end

  assign wdt_clear = (phase == PH_WRITE) & (op == OP_SLEEP);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag    <= `RST_TIMEOUT;
      power_down_flag <= `RST_PWRDOWN;
    end else if (wdt_clear) begin
      power_down_flag <= 1'b0;
      timeout_flag    <= 1'b1;
    end else if ((phase == PH_SLEEP) & wdt_expire) begin
      timeout_flag    <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_o   <= 1'b0;
      osc_run_o <= 1'b1;
    end else if (wdt_clear) begin
      sleep_o   <= 1'b1;
      osc_run_o <= 1'b0;
    end else if ((phase == PH_SLEEP) & wake_any) begin
      sleep_o   <= 1'b0;
      osc_run_o <= 1'b1;
    end
  end

  // the watchdog runs on core_clk_i, which is not gated here, so it counts through sleep
  watchdog_unit #(.COUNT_W(WDT_COUNT_W), .POST_W(WDT_POST_W)) u_watchdog (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .enable_i   (wdt_en),
    .clear_i    (wdt_clear),
    .expire_o   (wdt_expire),
    .cleared_o  ()
  );

  assign irq_event[`IRQ_SLEEP] = wdt_clear;
  assign irq_event[`IRQ_WAKE]  = (phase == PH_SLEEP) & wake_any;
  assign irq_event[`IRQ_WDT]   = wdt_expire;

  // a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat <= '0;
    end else if (bus_wr & (avs_address_i == `OFS_IRQ_STAT)) begin
      irq_stat <= (irq_stat & ~avs_writedata_i[`IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  sequence s_accept;
    (phase == PH_DECODE) && instr_valid_i && instr_ready_o;
  endsequence
  sequence s_phases;
    (phase == PH_READ) ##1 (phase == PH_PROCESS) ##1 (phase == PH_WRITE);
  endsequence
  property p_four_phase;
    @(posedge core_clk_i) disable iff (rst_i)
    s_accept |=> s_phases;
  endproperty
  a_four_phase: assert property (p_four_phase)
    else $error("instruction did not run four phases");
  property p_set_all;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_WRITE && op == OP_SETALL)
      |=> file_mem[$past(file_addr_op)] == 8'hff;
  endproperty
  a_set_all: assert property (p_set_all)
    else $error("set-all-ones did not write ff");
  property p_rot_file;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_READ) ##1 (op == OP_ROTATE && dest_file) ##1 1'b1
      |=> file_mem[$past(file_addr_op)] ==
          {$past(operand[0], 2), $past(operand[7:1], 2)};
  endproperty
  a_rot_file: assert property (p_rot_file)
    else $error("rotate to file gave a wrong value");
  property p_rot_acc;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_WRITE && op == OP_ROTATE && !dest_file)
      |=> accum == {$past(operand[0]), $past(operand[7:1])};
  endproperty
  a_rot_acc: assert property (p_rot_acc)
    else $error("rotate to accumulator gave a wrong value");
  property p_rot_one_bit;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_PROCESS) |-> rotated[6:0] == operand[7:1];
  endproperty
  a_rot_one_bit: assert property (p_rot_one_bit)
    else $error("rotate moved by other than one bit");
  property p_pwrdn_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_WRITE && op == OP_SLEEP) |=> !power_down_flag;
  endproperty
  a_pwrdn_clear: assert property (p_pwrdn_clear)
    else $error("power-down flag not cleared by sleep");
  property p_to_set;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_WRITE && op == OP_SLEEP) |=> timeout_flag;
  endproperty
  a_to_set: assert property (p_to_set)
    else $error("timeout flag not set by sleep");
  sequence s_enter_sleep;
    (phase == PH_WRITE && op == OP_SLEEP) ##1
      (sleep_o && !osc_run_o && phase == PH_SLEEP);
  endsequence
  property p_sleep_enter;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_WRITE && op == OP_SLEEP) |-> s_enter_sleep;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep not entered after sleep instruction");
  property p_sleep_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_SLEEP && !wake_any) |=> (phase == PH_SLEEP && sleep_o);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("execution resumed without a wake source");
  property p_wdt_wake;
    @(posedge core_clk_i) disable iff (rst_i)
    (phase == PH_SLEEP && wdt_expire) |=> !timeout_flag && !sleep_o;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog wake left timeout flag set");
  property p_bus_one_wait;
    @(posedge core_clk_i) disable iff (rst_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait)
    else $error("bus answer not given after one wait cycle");

endmodule // cpu_sleep_rotate_set_all_ones_instr_exec
`default_nettype wire

// ---- core/exec_defines.svh ----
// offsets, field positions, reset values and opcodes of the execution core
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// register byte offsets
`define OFS_STATUS    5'h00
`define OFS_ACCUM     5'h04
`define OFS_FILE_ADDR 5'h08
`define OFS_FILE_DATA 5'h0c
`define OFS_IRQ_STAT  5'h10
`define OFS_IRQ_MASK  5'h14
`define OFS_WDT_CTRL  5'h18
`define OFS_WAKE      5'h1c

// status register fields
`define STAT_TIMEOUT  0
`define STAT_PWRDOWN  1
`define STAT_SLEEPING 2

// interrupt fields
`define IRQ_SLEEP     0
`define IRQ_WAKE      1
`define IRQ_WDT       2
`define IRQ_BITS      3

// control fields
`define WDT_CTRL_EN   0
`define WAKE_REQ      0

// reset values
`define RST_TIMEOUT   1'b1
`define RST_PWRDOWN   1'b1
`define RST_WDT_EN    1'b0
`define RST_BYTE      8'h00

// instruction encodings
`define OPC_SETALL_HI 7'h34
`define OPC_ROT_HI    6'h10
`define OPC_SLEEP     16'h0003
`define ALL_ONES      8'hff

`endif

// ---- core/exec_pkg.sv ----
// types shared by the execution core
`default_nettype none
package exec_pkg;
  typedef enum logic [2:0] {
    PH_DECODE  = 3'b000,
    PH_READ    = 3'b001,
    PH_PROCESS = 3'b010,
    PH_WRITE   = 3'b011,
    PH_SLEEP   = 3'b100
  } phase_e;

  typedef enum logic [1:0] {
    OP_OTHER  = 2'b00,
    OP_SETALL = 2'b01,
    OP_ROTATE = 2'b10,
    OP_SLEEP  = 2'b11
  } op_e;
endpackage
`default_nettype wire

// ---- core/rotate_unit.sv ----
// one-bit right rotate without carry
`default_nettype none
module rotate_unit #(
  parameter int WIDTH = 8
) (
  // operand
  input  wire logic [WIDTH-1:0] operand_i,
  // result
  output logic      [WIDTH-1:0] result_o
);
  // bit 0 wraps into the top bit, exactly one position per use
  assign result_o = {operand_i[0], operand_i[WIDTH-1:1]};
endmodule // rotate_unit
`default_nettype wire

// ---- core/watchdog_unit.sv ----
// watchdog counter with postscaler and expiry pulse
`default_nettype none
module watchdog_unit #(
  parameter int COUNT_W = 8,
  parameter int POST_W  = 3
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic enable_i,
  input  wire logic clear_i,
  // status
  output logic      expire_o,
  output logic      cleared_o
);
  logic [COUNT_W-1:0] watchdog_counter;
  logic [POST_W-1:0]  postscale;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      watchdog_counter <= '0;
      postscale        <= '0;
    end else if (clear_i) begin
      watchdog_counter <= '0;
      postscale        <= '0;
    end else if (enable_i) begin
      watchdog_counter <= watchdog_counter + 1'b1;
      if (&watchdog_counter) begin
        postscale <= postscale + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      expire_o <= 1'b0;
    end else begin
      expire_o <= enable_i & ~clear_i & (&watchdog_counter) & (&postscale);
    end
  end

  assign cleared_o = (watchdog_counter == '0) && (postscale == '0);

  property p_wdt_clear;
    @(posedge core_clk_i) disable iff (rst_i)
    clear_i |=> cleared_o;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog not cleared on request");
endmodule // watchdog_unit
`default_nettype wire

// ---- bench/program_feed.sv ----
// program memory model offering instruction words one at a time
`default_nettype none
module program_feed (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // loading from the bench
  input  wire logic [15:0] word_i,
  input  wire logic        load_i,
  input  wire logic        slow_i,
  // instruction stream
  input  wire logic        ready_i,
  output logic      [15:0] instr_o,
  output logic             valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] fifo[$];
  int          wait_cnt;
  // a released word line shows the inverse, so a stale word never matches
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      instr_o <= 16'hffff;
      valid_o <= 1'b0;
      wait_cnt = 0;
      fifo.delete();
    end else begin
      if (load_i) begin
        fifo.push_back(word_i);
      end
      if (valid_o && ready_i) begin
        valid_o <= 1'b0;
        instr_o <= ~instr_o;
        wait_cnt = 0;
      end else if (!valid_o && fifo.size() > 0) begin
        // slow mode lets a few cycles pass before a word is offered
        if (!slow_i || wait_cnt >= 3) begin
          instr_o <= fifo.pop_front();
          valid_o <= 1'b1;
        end
        wait_cnt++;
      end
    end
  end
endmodule // program_feed
`default_nettype wire

// ---- bench/cpu_sleep_rotate_set_all_ones_instr_exec_test.sv ----
// self-checking bench for the four-phase executor
`include "exec_defines.svh"
`default_nettype none
module cpu_sleep_rotate_set_all_ones_instr_exec_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, instr_valid, instr_ready, wake;
  logic        sleeping, osc_run, irq, load, slow, gap_on;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [15:0] instr, word;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  int          mismatches, num_checks, gap;

  // short watchdog: 2^4 * 2^1 = 32 cycles
  cpu_sleep_rotate_set_all_ones_instr_exec #(.WDT_COUNT_W(4), .WDT_POST_W(1))
    u_cpu_sleep_rotate_set_all_ones_instr_exec (
    .core_clk_i(core_clk), .rst_i(rst), .instr_i(instr),
    .instr_valid_i(instr_valid), .instr_ready_o(instr_ready),
    .wake_i(wake), .sleep_o(sleeping), .osc_run_o(osc_run),
    .avs_address_i(avs_address), .avs_read_i(avs_read),
    .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
    .irq_o(irq));

  program_feed u_program_feed (
    .core_clk_i(core_clk), .rst_i(rst), .word_i(word), .load_i(load),
    .slow_i(slow), .ready_i(instr_ready), .instr_o(instr),
    .valid_o(instr_valid));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    check_bit(avs_waitrequest, 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    check_word(rd, e);
  endtask

  task automatic file_wr(input logic [7:0] f, input logic [7:0] v);
    wr(`OFS_FILE_ADDR, {24'h0, f});
    wr(`OFS_FILE_DATA, {24'h0, v});
  endtask

  task automatic file_chk(input logic [7:0] f, input logic [31:0] e);
    wr(`OFS_FILE_ADDR, {24'h0, f});
    rd_chk(`OFS_FILE_DATA, e);
  endtask

  task automatic push(input logic [15:0] w);
    @(posedge core_clk);
    word <= w;
    load <= 1'b1;
    @(posedge core_clk);
    load <= 1'b0;
  endtask

  // bounded wait for a flag to reach a level
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    int n;
    n = 0;
    while (sig !== lvl && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    check_bit(sig, lvl);
  endtask

  task automatic exec(input logic [15:0] w);
    int n;
    n = 0;
    push(w);
    do begin
      @(posedge core_clk);
      n++;
    end while ((instr_valid & instr_ready) !== 1'b1 && n < 20);
    check_bit(instr_valid & instr_ready, 1'b1);
    @(posedge core_clk);
    wait_for(instr_ready, 1'b1, 10);
  endtask

  // every accepted word other than sleep keeps ready low for exactly three cycles
  always @(posedge core_clk) begin
    if (rst) begin
      gap_on = 1'b0;
    end else if (instr_ready === 1'b1) begin
      if (gap_on)
        check_word(gap, 32'h3);
      gap_on = (instr_valid === 1'b1);
      gap = 0;
    end else begin
      gap++;
      if (sleeping === 1'b1)
        gap_on = 1'b0;
    end
  end

  initial begin
    rst = 1'b1;
    {load, slow, wake, avs_read, avs_write} = 5'h00;
    word = 16'h0000;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    mismatches = 0;
    num_checks = 0;
    gap = 0;
    gap_on = 1'b0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(`OFS_STATUS, 32'h3);
    rd_chk(5'h02, 32'h0);
    wr(`OFS_IRQ_MASK, 32'h1);
    wr(`OFS_ACCUM, 32'h3c);
    file_wr(8'h20, 8'h5a);
    exec(16'h6820);
    file_chk(8'h20, 32'hff);
    rd_chk(`OFS_ACCUM, 32'h3c);
    file_wr(8'h21, 8'hd7);
    file_wr(8'h22, 8'hd7);
    file_wr(8'h23, 8'h01);
    exec(16'h4221);
    file_chk(8'h21, 32'heb);
    slow <= 1'b1;
    exec(16'h4323);
    file_chk(8'h23, 32'h80);
    slow <= 1'b0;
    exec(16'h4022);
    rd_chk(`OFS_ACCUM, 32'heb);
    file_chk(8'h22, 32'hd7);
    // a near miss of the rotate code runs four phases with no effect
    exec(16'h4422);
    rd_chk(`OFS_ACCUM, 32'heb);
    file_chk(8'h22, 32'hd7);
    // two words queued back to back
    file_wr(8'h24, 8'h00);
    file_wr(8'h25, 8'h11);
    push(16'h6824);
    push(16'h6825);
    repeat (12) @(posedge core_clk);
    file_chk(8'h24, 32'hff);
    file_chk(8'h25, 32'hff);
    // sleep, woken by the wake pin
    file_wr(8'h26, 8'h00);
    push(16'h0003);
    wait_for(sleeping, 1'b1, 20);
    check_bit(osc_run, 1'b0);
    rd_chk(`OFS_STATUS, 32'h5);
    check_bit(irq, 1'b1);
    push(16'h6826);
    repeat (8) @(posedge core_clk);
    check_bit(instr_ready, 1'b0);
    file_chk(8'h26, 32'h00);
    wr(`OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge core_clk);
    check_bit(irq, 1'b0);
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    wait_for(sleeping, 1'b0, 10);
    check_bit(osc_run, 1'b1);
    repeat (8) @(posedge core_clk);
    file_chk(8'h26, 32'hff);
    rd_chk(`OFS_STATUS, 32'h1);
    rd_chk(`OFS_IRQ_STAT, 32'h2);
    check_bit(irq, 1'b0);
    wr(`OFS_IRQ_STAT, 32'h7);
    // sleep, woken by a write to the wake register
    push(16'h0003);
    wait_for(sleeping, 1'b1, 20);
    wr(`OFS_WAKE, 32'h1);
    wait_for(sleeping, 1'b0, 4);
    check_bit(osc_run, 1'b1);
    rd_chk(`OFS_STATUS, 32'h1);
    rd_chk(`OFS_IRQ_STAT, 32'h3);
    wr(`OFS_IRQ_STAT, 32'h7);
    // sleep entered close to expiry must restart the watchdog
    wr(`OFS_WDT_CTRL, 32'h1);
    repeat (20) @(posedge core_clk);
    push(16'h0003);
    wait_for(sleeping, 1'b1, 20);
    repeat (20) @(posedge core_clk);
    check_bit(sleeping, 1'b1);
    wait_for(sleeping, 1'b0, 40);
    rd_chk(`OFS_STATUS, 32'h0);
    rd_chk(`OFS_IRQ_STAT, 32'h7);
    wr(`OFS_WDT_CTRL, 32'h0);
    give_verdict();
  end

  // the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
endmodule // cpu_sleep_rotate_set_all_ones_instr_exec_test
`default_nettype wire
